/* File: rtl/dcc_channel.sv */
// Purpose: control, pacing, address stepping and issue of one transfer channel
// Assumes: wishbone classic slave; peripheral requests and timer pulses synchronous to clk_i
// Notes:   one issue per paced request; a two-entry buffer holds issued transfers
// Behaviour
// - transfers paced by selected request source
// - select up to 0x3a picks peripheral request
// - select 0x3b..0x3e picks timers zero to three
// - select 0x3f means request always present
// - completion triggers channel in link target
// - link equal own number disables; resets six
// - wrap side bit picks source or destination
// - wrap region n keeps upper bits fixed
// - destination step bit advances write address
// - source step bit advances read address
// - width code sets size and step amount
// - preferred channels first, one other between
// - preference affects issue order only
// - enabled channel starts on trigger, becomes busy
// - disabled channel ignores triggers, pauses, stays busy
// - busy rises at start, falls at end
`include "dcc_defs.svh"
module dcc_channel (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [58:0]       peripheral_data_request_i,
  input  wire logic [3:0]        pace_timer_i,
  input  wire logic              trigger_i,
  input  wire logic              grant_i,
  output logic                   preferred_o,
  output logic                   issue_req_o,
  output logic                   xfer_valid_o,
  input  wire logic              xfer_ready_i,
  output dcc_pkg::dcc_xfer_t     xfer_o,
  output logic                   chain_valid_o,
  output logic [3:0]             chain_target_o,
  output logic                   busy_o
);
  logic [31:0]          ctrl_ff;
  logic [31:0]          raddr_ff;
  logic [31:0]          waddr_ff;
  logic [31:0]          count_ff;
  logic                 busy_ff;
  dcc_pkg::dcc_state_t  state_ff;
  dcc_pkg::dcc_xfer_t   buf_ff [2];
  logic [1:0]           buf_vld_ff;
  logic                 wptr_ff;
  logic                 rptr_ff;
  logic                 chain_ff;
  logic [31:0]          rd_ff;
  logic                 ack_ff;
  logic                 pace_req;
  logic [5:0]           pace_sel;
  logic                 enable;
  logic                 buf_ready;
  logic                 do_issue;
  logic                 wb_wr;
  logic [31:0]          step;
  logic [31:0]          nxt_raddr;
  logic [31:0]          nxt_waddr;
  logic [31:0]          wrap_mask;
  logic [3:0]           wrap_n;
  dcc_pkg::dcc_width_t  xfer_width;

  // ==========================================================
  // register bus
  // a write lands at the edge where the master samples ack high
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_ff <= 32'h0000_0000;
    else
    begin
      case (wb_adr_i)
        `DCC_CTRL_OFS:  rd_ff <= ctrl_ff | ({31'h0000_0000, busy_ff} << `DCC_BUSY_BIT);
        `DCC_RADDR_OFS: rd_ff <= raddr_ff;
        `DCC_WADDR_OFS: rd_ff <= waddr_ff;
        `DCC_COUNT_OFS: rd_ff <= count_ff;
        `DCC_STAT_OFS:  rd_ff <= {30'h0000_0000, buf_vld_ff != 2'b00, busy_ff};
        default:        rd_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;

  // bytewise write of control; busy is read-only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_ff <= `DCC_CTRL_RST;
    else if (wb_wr && wb_adr_i == `DCC_CTRL_OFS)
    begin
      for (int i = 0; i < 4; i++)
        if (wb_sel_i[i])
          ctrl_ff[i*8 +: 8] <= wb_dat_i[i*8 +: 8] & 8'(`DCC_CTRL_MASK >> (i*8));
    end
  end

  // ==========================================================
  // pacing source selection
  assign pace_sel = ctrl_ff[`DCC_PACE_HI:`DCC_PACE_LO];
  assign enable   = ctrl_ff[`DCC_EN_BIT];

  always_comb
  begin
    pace_req = 1'b0;
    if (pace_sel <= `DCC_PERIPH_MAX)
      pace_req = peripheral_data_request_i[pace_sel];
    else if (pace_sel == `DCC_PERM_SEL)
      pace_req = 1'b1;
    else
      pace_req = pace_timer_i[2'(pace_sel - `DCC_TMR0_SEL)];
  end

  // ==========================================================
  // address stepping and ring wrap
  always_comb
  begin
    case (dcc_pkg::dcc_width_t'(ctrl_ff[`DCC_WID_HI:`DCC_WID_LO]))
      dcc_pkg::DCC_W_BYTE: step = 32'h0000_0001;
      dcc_pkg::DCC_W_HALF: step = 32'h0000_0002;
      default:             step = 32'h0000_0004;
    endcase
  end

  // code three is undefined; issue it as a word so the far side never sees it
  assign xfer_width = (ctrl_ff[`DCC_WID_HI:`DCC_WID_LO] == 2'h3) ? dcc_pkg::DCC_W_WORD
                    : dcc_pkg::dcc_width_t'(ctrl_ff[`DCC_WID_HI:`DCC_WID_LO]);

  assign wrap_n    = ctrl_ff[`DCC_WSZ_HI:`DCC_WSZ_LO];
  assign wrap_mask = (wrap_n == 4'h0) ? 32'hffff_ffff : ((32'h0000_0001 << wrap_n) - 32'h0000_0001);

  always_comb
  begin
    nxt_raddr = ctrl_ff[`DCC_SSTEP_BIT] ? raddr_ff + step : raddr_ff;
    nxt_waddr = ctrl_ff[`DCC_DSTEP_BIT] ? waddr_ff + step : waddr_ff;
    if (!ctrl_ff[`DCC_WSEL_BIT])
      nxt_raddr = (raddr_ff & ~wrap_mask) | (nxt_raddr & wrap_mask);
    else
      nxt_waddr = (waddr_ff & ~wrap_mask) | (nxt_waddr & wrap_mask);
  end

  // ==========================================================
  // sequence control
  assign buf_ready   = !buf_vld_ff[wptr_ff];
  assign preferred_o = ctrl_ff[`DCC_PREF_BIT];
  // issue only when scheduler grants; preference changes order, not bus priority
  assign do_issue    = state_ff == dcc_pkg::DCC_ISSUE && enable && grant_i && buf_ready;
  assign issue_req_o = state_ff == dcc_pkg::DCC_ISSUE && enable && buf_ready;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_ff <= dcc_pkg::DCC_IDLE;
    else
    begin
      case (state_ff)
        dcc_pkg::DCC_IDLE:
          if (trigger_i && enable && count_ff != 32'h0000_0000)
            state_ff <= dcc_pkg::DCC_WAIT;
        dcc_pkg::DCC_WAIT:
          if (enable && pace_req)
            state_ff <= dcc_pkg::DCC_ISSUE;
        dcc_pkg::DCC_ISSUE:
          if (do_issue)
            state_ff <= (count_ff == 32'h0000_0001) ? dcc_pkg::DCC_IDLE : dcc_pkg::DCC_WAIT;
        default:
          state_ff <= dcc_pkg::DCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_ff <= 1'b0;
    else if (state_ff == dcc_pkg::DCC_IDLE && trigger_i && enable && count_ff != 32'h0000_0000)
      busy_ff <= 1'b1;
    else if (do_issue && count_ff == 32'h0000_0001)
      busy_ff <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      raddr_ff <= 32'h0000_0000;
      waddr_ff <= 32'h0000_0000;
      count_ff <= 32'h0000_0000;
    end
    else
    begin
      if (wb_wr && wb_adr_i == `DCC_RADDR_OFS)
        raddr_ff <= wb_dat_i;
      else if (do_issue)
        raddr_ff <= nxt_raddr;
      if (wb_wr && wb_adr_i == `DCC_WADDR_OFS)
        waddr_ff <= wb_dat_i;
      else if (do_issue)
        waddr_ff <= nxt_waddr;
      if (wb_wr && wb_adr_i == `DCC_COUNT_OFS)
        count_ff <= wb_dat_i;
      else if (do_issue)
        count_ff <= count_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chain_ff <= 1'b0;
    else
      chain_ff <= do_issue && count_ff == 32'h0000_0001 &&
                  ctrl_ff[`DCC_LINK_HI:`DCC_LINK_LO] != `DCC_OWN_CHAN;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chain_target_o <= `DCC_OWN_CHAN;
    else if (do_issue)
      chain_target_o <= ctrl_ff[`DCC_LINK_HI:`DCC_LINK_LO];
  end

  assign chain_valid_o = chain_ff;
  assign busy_o        = busy_ff;

  // ==========================================================
  // two-entry transfer buffer; receiver stall holds issue
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      buf_vld_ff <= 2'b00;
      wptr_ff    <= 1'b0;
      rptr_ff    <= 1'b0;
    end
    else
    begin
      if (do_issue)
      begin
        buf_ff[wptr_ff] <= '{raddr: raddr_ff, waddr: waddr_ff, width: xfer_width};
        buf_vld_ff[wptr_ff] <= 1'b1;
        wptr_ff <= ~wptr_ff;
      end
      if (buf_vld_ff[rptr_ff] && xfer_ready_i)
      begin
        buf_vld_ff[rptr_ff] <= 1'b0;
        rptr_ff <= ~rptr_ff;
      end
    end
  end

  assign xfer_valid_o = buf_vld_ff[rptr_ff];
  assign xfer_o       = buf_ff[rptr_ff];

  // ==========================================================
  // checks
  property p_busy_end;
    @(posedge clk_i) disable iff (rst_i)
    (do_issue && count_ff == 32'h0000_0001) |=> !busy_ff;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy not cleared");

  property p_pause;
    @(posedge clk_i) disable iff (rst_i)
    (!enable && busy_ff) |=> busy_ff;
  endproperty
  a_pause: assert property (p_pause) else $error("busy lost while paused");

  property p_no_issue_off;
    @(posedge clk_i) disable iff (rst_i)
    (!enable && !wb_wr) |=> count_ff == $past(count_ff);
  endproperty
  a_no_issue_off: assert property (p_no_issue_off) else $error("issue while disabled");

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == dcc_pkg::DCC_IDLE && trigger_i && enable && count_ff != 32'h0000_0000) |=>
      (busy_ff && state_ff == dcc_pkg::DCC_WAIT);
  endproperty
  a_start: assert property (p_start) else $error("trigger did not start");

  property p_self_link;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_ff[`DCC_LINK_HI:`DCC_LINK_LO] == `DCC_OWN_CHAN) |=> !chain_ff;
  endproperty
  a_self_link: assert property (p_self_link) else $error("completion_link_target self");

  property p_fixed_src;
    @(posedge clk_i) disable iff (rst_i)
    (do_issue && !ctrl_ff[`DCC_SSTEP_BIT] && !wb_wr) |=> raddr_ff == $past(raddr_ff);
  endproperty
  a_fixed_src: assert property (p_fixed_src) else $error("source moved");

  property p_fixed_dst;
    @(posedge clk_i) disable iff (rst_i)
    (do_issue && !ctrl_ff[`DCC_DSTEP_BIT] && !wb_wr) |=> waddr_ff == $past(waddr_ff);
  endproperty
  a_fixed_dst: assert property (p_fixed_dst) else $error("destination moved");

  property p_paced;
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == dcc_pkg::DCC_WAIT && !pace_req) |=> state_ff != dcc_pkg::DCC_ISSUE;
  endproperty
  a_paced: assert property (p_paced) else $error("issue without request");
endmodule

/* File: rtl/dcc_defs.svh */
// Purpose: offsets, field positions, reset values for the channel six control block
// Assumes: 32-bit classic wishbone register bus, byte addresses
// Notes:   definitions only
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
`define DCC_CTRL_OFS      8'h00
`define DCC_RADDR_OFS     8'h04
`define DCC_WADDR_OFS     8'h08
`define DCC_COUNT_OFS     8'h0c
`define DCC_STAT_OFS      8'h10
`define DCC_PACE_HI       20
`define DCC_PACE_LO       15
`define DCC_LINK_HI       14
`define DCC_LINK_LO       11
`define DCC_WSEL_BIT      10
`define DCC_WSZ_HI        9
`define DCC_WSZ_LO        6
`define DCC_DSTEP_BIT     5
`define DCC_SSTEP_BIT     4
`define DCC_WID_HI        3
`define DCC_WID_LO        2
`define DCC_PREF_BIT      1
`define DCC_EN_BIT        0
`define DCC_BUSY_BIT      24
`define DCC_OWN_CHAN      4'h6
`define DCC_PERIPH_MAX    6'h3a
`define DCC_TMR0_SEL      6'h3b
`define DCC_PERM_SEL      6'h3f
`define DCC_PERIPH_N      59
`define DCC_CTRL_RST      32'h0000_3000
`define DCC_CTRL_MASK     32'h001f_ffff
`endif

/* File: rtl/dcc_pkg.sv */
// Purpose: types for the channel six control block
// Assumes: constants live in dcc_defs.svh
// Notes:   the transfer request carries address and width together
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_W_BYTE,
    DCC_W_HALF,
    DCC_W_WORD,
    DCC_W_RSVD
  } dcc_width_t;

  typedef struct packed {
    logic [31:0] raddr;
    logic [31:0] waddr;
    dcc_width_t  width;
  } dcc_xfer_t;

  typedef enum logic [1:0] {
    DCC_IDLE,
    DCC_WAIT,
    DCC_ISSUE
  } dcc_state_t;
endpackage

/* File: verification/dcc_sink.sv */
// Purpose: far-side model taking issued transfers from the channel
// Assumes: valid/ready handshake, grant from an outside scheduler
// Notes:   stall_i makes ready and grant drop at random
module dcc_sink (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          stall_i,
  input  wire logic          xfer_valid_i,
  output logic               xfer_ready_o,
  output logic               grant_o,
  input  dcc_pkg::dcc_xfer_t xfer_i
);
  timeunit 1ns;
  timeprecision 1ns;
  dcc_pkg::dcc_xfer_t got_q[$];
  // ==========================================
  // accept and grant
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xfer_ready_o <= 1'b0;
      grant_o      <= 1'b0;
    end
    else
    begin
      xfer_ready_o <= !stall_i || ($urandom % 4 == 0);
      // grant ignores the preferred flag, as bus priority does
      grant_o      <= !stall_i || ($urandom % 2 == 0);
      if (xfer_valid_i === 1'b1 && xfer_ready_o)
        got_q.push_back(xfer_i);
    end
  end
endmodule

/* File: verification/tb.sv */
// Purpose: self-checking bench for the channel control block
// Assumes: one-wait wishbone answers, far side in dcc_sink
// Notes:   seed fixed, corner selects first then random ones
`include "dcc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_i, rst_i, cyc, stb, we, ack, trig, grant, pref, ireq, xv, xr, cv, busy, stall;
  logic [7:0]         adr;
  logic [3:0]         ctgt, tmr, sel;
  logic [31:0]        wdat, rdat, rd;
  logic [58:0]        preq;
  dcc_pkg::dcc_xfer_t xf;
  int                 num_errors, checks_done, chains, i;
  logic [5:0]         sels[8] = '{6'h00, 6'h3a, 6'h11, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f};

  dcc_channel i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .peripheral_data_request_i(preq), .pace_timer_i(tmr), .trigger_i(trig), .grant_i(grant),
    .preferred_o(pref), .issue_req_o(ireq), .xfer_valid_o(xv), .xfer_ready_i(xr), .xfer_o(xf),
    .chain_valid_o(cv), .chain_target_o(ctgt), .busy_o(busy));
  dcc_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .xfer_valid_i(xv),
    .xfer_ready_o(xr), .grant_o(grant), .xfer_i(xf));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (cv === 1'b1)
      chains <= chains + 1;

  // ==========================================
  // shared tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up(input int n);
    if (n >= 400)
    begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 400);
    give_up(n);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_for(input logic v, input int cnt);
    int n;
    n = 0;
    while ((busy !== v || i_sink.got_q.size() < cnt) && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    give_up(n);
  endtask

  // wrap keeps the bits above the region, so only the low n bits move
  function automatic logic [31:0] step(input logic [31:0] a, input logic on, input logic [1:0] w,
                                       input logic [3:0] n);
    logic [31:0] m;
    logic [31:0] b;
    m = (32'h1 << n) - 32'h1;
    b = on ? a + (32'h1 << ((w == 2'h3) ? 2'h2 : w)) : a;
    return (n == 4'h0) ? b : ((a & ~m) | (b & m));
  endfunction

  // ==========================================
  // one paced sequence
  task automatic run(input logic [31:0] ctl, input int cnt);
    logic [31:0] ra, wa;
    logic [5:0]  s;
    int          k, c0;
    s = ctl[20:15];
    ra = $urandom;
    wa = $urandom;
    c0 = chains;
    wb(1'b1, `DCC_RADDR_OFS, ra);
    wb(1'b1, `DCC_WADDR_OFS, wa);
    wb(1'b1, `DCC_COUNT_OFS, cnt);
    wb(1'b1, `DCC_CTRL_OFS, ctl & ~32'h1);
    trig <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(busy, 0);
    trig <= 1'b0;
    preq <= (s <= 6'h3a) ? ~(59'h1 << s) : '1;
    tmr  <= (s > 6'h3a && s < 6'h3f) ? ~(4'h1 << (s - 6'h3b)) : 4'hf;
    wb(1'b1, `DCC_CTRL_OFS, ctl);
    wb(1'b0, `DCC_CTRL_OFS, 0);
    check(rd, ctl & `DCC_CTRL_MASK);
    check(pref, ctl[1]);
    trig <= 1'b1;
    wait_for(1'b1, 0);
    trig <= 1'b0;
    repeat (10) @(posedge clk_i);
    if (s != 6'h3f)
    begin
      check(i_sink.got_q.size(), 0);
      check(ireq, 0);
      wb(1'b1, `DCC_CTRL_OFS, ctl & ~32'h1);
      preq <= '1;
      tmr  <= 4'hf;
      repeat (10) @(posedge clk_i);
      check(i_sink.got_q.size(), 0);
      check(ireq, 0);
      check(busy, 1);
      wb(1'b1, `DCC_CTRL_OFS, ctl);
    end
    wait_for(1'b0, cnt);
    repeat (2) @(posedge clk_i);
    check(i_sink.got_q.size(), cnt);
    for (k = 0; k < cnt; k++)
    begin
      check(i_sink.got_q[k].raddr, ra);
      check(i_sink.got_q[k].waddr, wa);
      check(i_sink.got_q[k].width, (ctl[3:2] == 2'h3) ? 2'h2 : ctl[3:2]);
      ra = step(ra, ctl[4], ctl[3:2], ctl[10] ? 4'h0 : ctl[9:6]);
      wa = step(wa, ctl[5], ctl[3:2], ctl[10] ? ctl[9:6] : 4'h0);
    end
    check(chains - c0, ctl[14:11] != `DCC_OWN_CHAN);
    check(ctgt, ctl[14:11]);
    i_sink.got_q.delete();
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    void'($urandom(7187));
    {rst_i, cyc, stb, we, trig, stall} = 6'b100000;
    sel = 4'hf;
    {adr, wdat, preq, tmr, num_errors, checks_done, chains} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(ctgt, `DCC_OWN_CHAN);
    wb(1'b0, `DCC_CTRL_OFS, 0);
    check(rd, `DCC_CTRL_RST);
    wb(1'b1, 8'h14, 32'hffff_ffff);
    wb(1'b0, 8'h14, 0);
    check(rd, 0);
    // only the low byte lane is written; the link field keeps its reset value
    sel <= 4'h1;
    wb(1'b1, `DCC_CTRL_OFS, 32'hffff_ffff);
    sel <= 4'hf;
    wb(1'b0, `DCC_CTRL_OFS, 0);
    check(rd, `DCC_CTRL_RST | 32'h0000_00ff);
    for (i = 0; i < 16; i++)
    begin
      stall <= i[0];
      // software keeps both source and destination steps off on odd rounds
      run({11'h0, (i < 8) ? sels[i] : 6'($urandom % 64), 4'($urandom), 5'($urandom),
           i[0] ? 2'b00 : 2'($urandom), 2'(i), 1'($urandom), 1'b1}, 1 + $urandom % 4);
    end
    stop_test();
  end
endmodule
